// ### include/ascc_pkg.sv
// Package with the register map, field layout and timing constants of the scan and clock control.
package ascc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFS_MAIN_CTRL   = 4'h0;
	localparam logic [3:0] OFS_SECOND_CTRL = 4'h1;
	localparam logic [3:0] OFS_CLK_CFG     = 4'h2;
	localparam logic [3:0] OFS_MUX_SEL     = 4'h3;
	localparam logic [3:0] OFS_SCAN_LO     = 4'h4;
	localparam logic [3:0] OFS_SCAN_HI     = 4'h5;
	localparam logic [3:0] OFS_IRQ_STAT    = 4'h6;
	localparam logic [3:0] OFS_IRQ_MASK    = 4'h7;
	localparam int BIT_MODULE_ON   = 15;
	localparam int BIT_REF_LSB     = 13;
	localparam int BIT_SCAN_ENABLE = 10;
	localparam int BIT_ALT_MUX     = 0;
	localparam int BIT_RC_SEL      = 15;
	localparam int DIV_W           = 6;
	localparam int BIT_MUXA_LSB    = 0;
	localparam int BIT_MUXB_LSB    = 8;
	localparam int CHSEL_W         = 5;
	localparam int SCAN_HI_W       = 2;
	localparam int SCAN_W          = 18;
	localparam int REF_UP_EXT_BIT  = 0;
	localparam int REF_LO_EXT_BIT  = 1;
	localparam int REF_RAIL_BIT    = 2;
	localparam int IRQ_DONE        = 0;
	localparam int IRQ_WRAP        = 1;
	localparam int IRQ_W           = 2;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam int CONV_TAD        = 12;
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int TAD_MIN_NS      = 75;
	localparam int TAD_MIN_CYC     = (TAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	typedef enum logic [1:0] {
		ASCC_IDLE = 2'b01,
		ASCC_CONV = 2'b10
	} ascc_state_t;
endpackage : ascc_pkg

// ### include/ascc_clk_if.sv
// Interface between the control core and the conversion clock generator.
`timescale 1ns/1ps
interface ascc_clk_if;
	logic                     run;
	logic                     rc_sel;
	logic                     rc_tick;
	logic [ascc_pkg::DIV_W-1:0] divider;
	logic                     tad_tick;
	modport ctrl (output run, output rc_sel, output rc_tick, output divider, input tad_tick);
	modport gen (input run, input rc_sel, input rc_tick, input divider, output tad_tick);
endinterface : ascc_clk_if

// ### verilog/ascc_tad_gen.sv
// Conversion clock generator: divided instruction clock or the dedicated RC source.
`timescale 1ns/1ps
module ascc_tad_gen #(
	parameter int CNT_W = ascc_pkg::DIV_W
) (
	input  wire logic clk_sys,
	input  wire logic srst,
	ascc_clk_if.gen   cif
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             tick;
	} ascc_gen_t;

	ascc_gen_t q;
	ascc_gen_t n;

	if (CNT_W != ascc_pkg::DIV_W) begin : g_bad_width
		$error("Divider counter width must match the divider field.");
	end

	always_comb begin
		n = q;
		n.tick = 1'b0;
		if (!cif.run) begin
			n.cnt = '0;
		end else if (cif.rc_sel) begin
			n.cnt = '0;
			n.tick = cif.rc_tick;
		end else if (q.cnt >= cif.divider) begin
			n.cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign cif.tad_tick = q.tick;

	logic [6:0] gap_q;
	logic       seen_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			gap_q <= 7'h00;
			seen_q <= 1'b0;
		end else begin
			gap_q <= q.tick ? 7'h01 : ((gap_q == 7'h7f) ? gap_q : gap_q + 7'h01);
			if (!cif.run || cif.rc_sel || (cif.divider != q.cnt && q.cnt > cif.divider)) begin
				seen_q <= 1'b0;
			end else if (q.tick) begin
				seen_q <= 1'b1;
			end
		end
	end

	property p_div_period;
		@(posedge clk_sys) disable iff (srst)
		(seen_q && q.tick && $stable(cif.divider) && $past(cif.run) && !$past(cif.rc_sel))
			|-> gap_q == {1'b0, cif.divider} + 7'h01;
	endproperty
	a_div_period: assert property (p_div_period) else $error("Divided clock period wrong.");

	property p_rc_pass;
		@(posedge clk_sys) disable iff (srst)
		(cif.run && cif.rc_sel) |=> q.tick == $past(cif.rc_tick);
	endproperty
	a_rc_pass: assert property (p_rc_pass) else $error("RC tick not passed through.");
endmodule : ascc_tad_gen

// ### verilog/ascc_core.sv
// Scan selection, reference selection and conversion clock control of the converter.
`timescale 1ns/1ps
module ascc_core #(
	parameter int CONV_TADS = ascc_pkg::CONV_TAD
) (
	input  wire logic                        clk_sys,
	input  wire logic                        srst,
	input  wire logic [ascc_pkg::ADDR_W-1:0] addr,
	input  wire logic [ascc_pkg::DATA_W-1:0] wdata,
	input  wire logic                        wr,
	input  wire logic                        rd,
	output logic      [ascc_pkg::DATA_W-1:0] rdata,
	output logic                             irq,
	input  wire logic                        conv_start,
	input  wire logic                        intr_event,
	input  wire logic                        rc_tick,
	output logic      [ascc_pkg::CHSEL_W-1:0] active_channel,
	output logic                             mux_b_active,
	output logic                             upper_ref_ext,
	output logic                             lower_ref_ext,
	output logic                             converting,
	output logic                             conv_done,
	output logic                             tad_clk
);
	localparam int CH_W = ascc_pkg::CHSEL_W;
	localparam int SW = ascc_pkg::SCAN_W;

	if (CONV_TADS < 1 || CONV_TADS > 15) begin : g_bad_len
		$error("Conversion length must fit the four-bit period counter.");
	end

	typedef struct packed {
		ascc_pkg::ascc_state_t           st;
		logic                            module_on;
		logic [2:0]                      ref_cfg;
		logic                            scan_en;
		logic                            alt_mux;
		logic                            rc_sel;
		logic [ascc_pkg::DIV_W-1:0]      div;
		logic [CH_W-1:0]                 mux_a;
		logic [CH_W-1:0]                 mux_b;
		logic [15:0]                     scan_lo;
		logic [ascc_pkg::SCAN_HI_W-1:0]  scan_hi;
		logic [ascc_pkg::IRQ_W-1:0]      stat;
		logic [ascc_pkg::IRQ_W-1:0]      mask;
		logic [CH_W-1:0]                 scan_idx;
		logic                            use_b;
		logic [3:0]                      tad_cnt;
		logic [ascc_pkg::DATA_W-1:0]     rdata;
		logic                            irq;
		logic [CH_W-1:0]                 chan;
		logic                            b_act;
		logic                            up_ext;
		logic                            lo_ext;
		logic                            busy;
		logic                            done;
	} ascc_regs_t;

	localparam ascc_regs_t REGS_RST = '{st: ascc_pkg::ASCC_IDLE, default: '0};

	ascc_regs_t q;
	ascc_regs_t n;
	logic [SW-1:0] scan_mask;
	logic [ascc_pkg::IRQ_W-1:0] ev;
	logic [ascc_pkg::IRQ_W-1:0] w1c;
	logic [CH_W-1:0] step_idx;
	logic tad_tick;

	ascc_clk_if cif ();

	ascc_tad_gen u_tad_gen (
		.clk_sys (clk_sys),
		.srst    (srst),
		.cif     (cif)
	);

	assign cif.run = q.module_on;
	assign cif.rc_sel = q.rc_sel;
	assign cif.rc_tick = rc_tick;
	assign cif.divider = q.div;
	assign tad_tick = cif.tad_tick;

	// Channel 16 is the half band gap and channel 17 the full band gap.
	assign scan_mask = {q.scan_hi, q.scan_lo};

	// Lowest selected channel; zero when the mask is empty.
	function automatic logic [CH_W-1:0] ascc_first(input logic [SW-1:0] m);
		logic [CH_W-1:0] r;
		r = '0;
		for (int i = SW - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = CH_W'(i);
			end
		end
		return r;
	endfunction : ascc_first

	// Next selected channel above cur, wrapping to the lowest one.
	function automatic logic [CH_W-1:0] ascc_next(input logic [SW-1:0] m,
			input logic [CH_W-1:0] cur);
		logic [CH_W-1:0] r;
		r = ascc_first(m);
		for (int i = SW - 1; i >= 0; i--) begin
			if (m[i] && CH_W'(i) > cur) begin
				r = CH_W'(i);
			end
		end
		return r;
	endfunction : ascc_next

	always_comb begin
		n = q;
		ev = '0;
		w1c = '0;
		step_idx = ascc_next(scan_mask, q.scan_idx);
		n.rdata = '0;
		n.done = 1'b0;

		if (wr) begin
			case (addr)
				ascc_pkg::OFS_MAIN_CTRL: begin
					n.module_on = wdata[ascc_pkg::BIT_MODULE_ON];
				end
				ascc_pkg::OFS_SECOND_CTRL: begin
					n.ref_cfg = wdata[ascc_pkg::BIT_REF_LSB +: 3];
					n.scan_en = wdata[ascc_pkg::BIT_SCAN_ENABLE];
					n.alt_mux = wdata[ascc_pkg::BIT_ALT_MUX];
				end
				ascc_pkg::OFS_CLK_CFG: begin
					n.rc_sel = wdata[ascc_pkg::BIT_RC_SEL];
					n.div = wdata[ascc_pkg::DIV_W-1:0];
				end
				ascc_pkg::OFS_MUX_SEL: begin
					n.mux_a = wdata[ascc_pkg::BIT_MUXA_LSB +: CH_W];
					n.mux_b = wdata[ascc_pkg::BIT_MUXB_LSB +: CH_W];
				end
				ascc_pkg::OFS_SCAN_LO: begin
					n.scan_lo = wdata;
				end
				ascc_pkg::OFS_SCAN_HI: begin
					n.scan_hi = wdata[ascc_pkg::SCAN_HI_W-1:0];
				end
				ascc_pkg::OFS_IRQ_STAT: begin
					w1c = wdata[ascc_pkg::IRQ_W-1:0];
				end
				ascc_pkg::OFS_IRQ_MASK: begin
					n.mask = wdata[ascc_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		case (q.st)
			ascc_pkg::ASCC_IDLE: begin
				if (q.module_on && conv_start) begin
					n.st = ascc_pkg::ASCC_CONV;
					n.tad_cnt = 4'h0;
				end
			end
			ascc_pkg::ASCC_CONV: begin
				// Switching the module off abandons the conversion without a result.
				if (!q.module_on) begin
					n.st = ascc_pkg::ASCC_IDLE;
				end else if (tad_tick) begin
					if (q.tad_cnt == 4'(CONV_TADS - 1)) begin
						n.st = ascc_pkg::ASCC_IDLE;
						n.done = 1'b1;
						ev[ascc_pkg::IRQ_DONE] = 1'b1;
						if (q.alt_mux) begin
							n.use_b = !q.use_b;
						end
						if (!q.use_b && q.scan_en) begin
							n.scan_idx = step_idx;
							ev[ascc_pkg::IRQ_WRAP] = (step_idx <= q.scan_idx);
						end
					end else begin
						n.tad_cnt = q.tad_cnt + 4'h1;
					end
				end
			end
			default: begin
				n.st = ascc_pkg::ASCC_IDLE;
			end
		endcase

		// A converter interrupt restarts the scan and the alternation on the first mux.
		if (!q.module_on || intr_event) begin
			n.scan_idx = ascc_first(scan_mask);
			n.use_b = 1'b0;
		end

		// The second mux always takes its fixed channel; only the first one scans.
		if (n.use_b) begin
			n.chan = q.mux_b;
		end else if (q.scan_en) begin
			n.chan = n.scan_idx;
		end else begin
			// Channels 0 and 1 stay selectable whatever the references use.
			n.chan = q.mux_a;
		end
		n.b_act = n.use_b;
		n.busy = (n.st == ascc_pkg::ASCC_CONV);

		// A rail setting in the top bit forces both references to the supplies.
		n.up_ext = !q.ref_cfg[ascc_pkg::REF_RAIL_BIT] && q.ref_cfg[ascc_pkg::REF_UP_EXT_BIT];
		n.lo_ext = !q.ref_cfg[ascc_pkg::REF_RAIL_BIT] && q.ref_cfg[ascc_pkg::REF_LO_EXT_BIT];

		// A new event beats a clear that lands in the same cycle.
		n.stat = (q.stat & ~w1c) | ev;
		n.irq = |(q.stat & q.mask);

		if (rd) begin
			case (addr)
				ascc_pkg::OFS_MAIN_CTRL: begin
					n.rdata[ascc_pkg::BIT_MODULE_ON] = q.module_on;
				end
				ascc_pkg::OFS_SECOND_CTRL: begin
					n.rdata[ascc_pkg::BIT_REF_LSB +: 3] = q.ref_cfg;
					n.rdata[ascc_pkg::BIT_SCAN_ENABLE] = q.scan_en;
					n.rdata[ascc_pkg::BIT_ALT_MUX] = q.alt_mux;
				end
				ascc_pkg::OFS_CLK_CFG: begin
					n.rdata[ascc_pkg::BIT_RC_SEL] = q.rc_sel;
					n.rdata[ascc_pkg::DIV_W-1:0] = q.div;
				end
				ascc_pkg::OFS_MUX_SEL: begin
					n.rdata[ascc_pkg::BIT_MUXA_LSB +: CH_W] = q.mux_a;
					n.rdata[ascc_pkg::BIT_MUXB_LSB +: CH_W] = q.mux_b;
				end
				ascc_pkg::OFS_SCAN_LO: begin
					n.rdata = q.scan_lo;
				end
				ascc_pkg::OFS_SCAN_HI: begin
					n.rdata[ascc_pkg::SCAN_HI_W-1:0] = q.scan_hi;
				end
				ascc_pkg::OFS_IRQ_STAT: begin
					n.rdata[ascc_pkg::IRQ_W-1:0] = q.stat;
				end
				ascc_pkg::OFS_IRQ_MASK: begin
					n.rdata[ascc_pkg::IRQ_W-1:0] = q.mask;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			q <= REGS_RST;
		end else begin
			q <= n;
		end
	end

	assign rdata = q.rdata;
	assign irq = q.irq;
	assign active_channel = q.chan;
	assign mux_b_active = q.b_act;
	assign upper_ref_ext = q.up_ext;
	assign lower_ref_ext = q.lo_ext;
	assign converting = q.busy;
	assign conv_done = q.done;
	assign tad_clk = cif.tad_tick;

	// Converter clock periods seen in the running conversion.
	logic [4:0] conv_ticks_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			conv_ticks_q <= 5'h00;
		end else if (q.st == ascc_pkg::ASCC_IDLE) begin
			conv_ticks_q <= 5'h00;
		end else if (tad_tick) begin
			conv_ticks_q <= conv_ticks_q + 5'h01;
		end
	end

	property p_conv_len;
		@(posedge clk_sys) disable iff (srst)
		q.done |-> conv_ticks_q == 5'(CONV_TADS);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("Conversion length wrong.");

	property p_ref_ext;
		@(posedge clk_sys) disable iff (srst)
		(q.ref_cfg == 3'h3) |=> (q.up_ext && q.lo_ext);
	endproperty
	a_ref_ext: assert property (p_ref_ext) else $error("External references not selected.");

	property p_ref_rail;
		@(posedge clk_sys) disable iff (srst)
		q.ref_cfg[ascc_pkg::REF_RAIL_BIT] |=> (!q.up_ext && !q.lo_ext);
	endproperty
	a_ref_rail: assert property (p_ref_rail) else $error("Rail references not selected.");

	property p_scan_member;
		@(posedge clk_sys) disable iff (srst)
		(q.busy && !q.b_act && q.scan_en && scan_mask != '0 && $stable(scan_mask))
			|-> scan_mask[q.chan];
	endproperty
	a_scan_member: assert property (p_scan_member) else $error("Scanned channel not in mask.");

	property p_mux_b_fixed;
		@(posedge clk_sys) disable iff (srst)
		(q.b_act && $stable(q.mux_b)) |-> q.chan == q.mux_b;
	endproperty
	a_mux_b_fixed: assert property (p_mux_b_fixed) else $error("Second mux left its channel.");

	property p_scan_ignores_a;
		@(posedge clk_sys) disable iff (srst)
		(q.scan_en && !n.use_b && scan_mask != '0 && !scan_mask[q.mux_a])
			|=> q.chan != $past(q.mux_a);
	endproperty
	a_scan_ignores_a: assert property (p_scan_ignores_a) else $error("Scan used fixed channel.");

	property p_restart;
		@(posedge clk_sys) disable iff (srst)
		(intr_event && q.module_on) |=> q.scan_idx == ascc_first($past(scan_mask)) && !q.use_b;
	endproperty
	a_restart: assert property (p_restart) else $error("Scan did not restart.");

	property p_hi_read;
		@(posedge clk_sys) disable iff (srst)
		(rd && addr == ascc_pkg::OFS_SCAN_HI)
			|=> q.rdata == {14'h0000, $past(q.scan_hi)};
	endproperty
	a_hi_read: assert property (p_hi_read) else $error("High mask read wrong.");

	property p_lo_rw;
		@(posedge clk_sys) disable iff (srst)
		(wr && addr == ascc_pkg::OFS_SCAN_LO) ##1 (rd && addr == ascc_pkg::OFS_SCAN_LO)
			|=> q.rdata == $past(wdata, 2);
	endproperty
	a_lo_rw: assert property (p_lo_rw) else $error("Low mask write lost.");

	property p_irq_level;
		@(posedge clk_sys) disable iff (srst)
		(|(q.stat & q.mask)) |=> q.irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised.");

	c_done: cover property (@(posedge clk_sys) disable iff (srst) q.done);
	c_wrap: cover property (@(posedge clk_sys) disable iff (srst) q.stat[ascc_pkg::IRQ_WRAP]);
	c_mux_b: cover property (@(posedge clk_sys) disable iff (srst) q.b_act && q.busy);
	c_rc_conv: cover property (@(posedge clk_sys) disable iff (srst) q.rc_sel && q.done);
endmodule : ascc_core

// ### dv/ascc_far_model.sv
// Far-side model: the RC oscillator and the outside converter interrupt logic.
`timescale 1ns/1ps
module ascc_far_model (
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic [5:0] rc_period,
	input  wire logic [3:0] smp_per_irq,
	input  wire logic       conv_done,
	output logic            rc_tick,
	output logic            intr_event
);
	logic [5:0] rc_cnt_r;
	logic [3:0] smp_cnt_r;
	// A zero period holds the oscillator still; the bench starts it before RC conversions.
	always_ff @(posedge clk_sys) begin
		if (srst || rc_period == 6'h00) begin
			rc_cnt_r <= 6'h00;
			rc_tick  <= 1'b0;
		end else begin
			rc_tick  <= (rc_cnt_r == rc_period - 6'h01);
			rc_cnt_r <= (rc_cnt_r == rc_period - 6'h01) ? 6'h00 : rc_cnt_r + 6'h01;
		end
	end
	// The interrupt follows every smp_per_irq conversions, so the scan restarts there.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			smp_cnt_r  <= 4'h0;
			intr_event <= 1'b0;
		end else begin
			intr_event <= 1'b0;
			if (conv_done && smp_per_irq != 4'h0) begin
				intr_event <= (smp_cnt_r == smp_per_irq - 4'h1);
				smp_cnt_r  <= (smp_cnt_r == smp_per_irq - 4'h1) ? 4'h0 : smp_cnt_r + 4'h1;
			end
		end
	end
endmodule : ascc_far_model

// ### dv/tb_top.sv
// Self-checking testbench of the scan and conversion clock control.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys, srst, wr, rd, conv_start;
	logic [3:0] addr, smp;
	logic [15:0] wdata, rdata;
	logic [5:0] rc_period;
	logic [4:0] active_channel;
	logic irq, intr_event, rc_tick, mux_b_active, upper_ref_ext, lower_ref_ext;
	logic converting, conv_done, tad_clk;
	int err_count, tests_run, seed;
	ascc_core #(.CONV_TADS(12)) ascc_core_i (.clk_sys(clk_sys), .srst(srst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .conv_start(conv_start),
		.intr_event(intr_event), .rc_tick(rc_tick), .active_channel(active_channel),
		.mux_b_active(mux_b_active), .upper_ref_ext(upper_ref_ext),
		.lower_ref_ext(lower_ref_ext), .converting(converting), .conv_done(conv_done),
		.tad_clk(tad_clk));
	ascc_far_model ascc_far_model_i (.clk_sys(clk_sys), .srst(srst), .rc_period(rc_period),
		.smp_per_irq(smp), .conv_done(conv_done), .rc_tick(rc_tick), .intr_event(intr_event));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg
	// Starts right after an edge, so a read may follow a write with no idle cycle.
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	function automatic logic [15:0] impl_mask(input logic [3:0] a);
		case (a)
			4'h0: return 16'h8000;
			4'h1: return 16'he401;
			4'h2: return 16'h803f;
			4'h3: return 16'h1f1f;
			4'h4: return 16'hffff;
			4'h5, 4'h6, 4'h7: return 16'h0003;
			default: return 16'h0000;
		endcase
	endfunction : impl_mask
	function automatic int next_ch(input logic [17:0] m, input int cur);
		for (int i = cur + 1; i < 18; i++) if (m[i]) return i;
		for (int i = 0; i < 18; i++) if (m[i]) return i;
		return 0;
	endfunction : next_ch
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_cyc
	// Counts the converter clock pulses that fall inside one conversion.
	task automatic convert(output int tads);
		int k;
		tads = 0;
		k = 0;
		@(posedge clk_sys);
		conv_start <= 1'b1;
		@(posedge clk_sys);
		conv_start <= 1'b0;
		#1;
		while (conv_done !== 1'b1 && k < 2000) begin
			if (converting === 1'b1 && tad_clk === 1'b1) tads++;
			wait_cyc(1);
			k++;
		end
	endtask : convert
	task automatic tad_gap(output int g);
		int k;
		k = 0;
		do begin wait_cyc(1); k++; end while (tad_clk !== 1'b1 && k < 200);
		g = 0;
		do begin wait_cyc(1); g++; end while (tad_clk !== 1'b1 && g < 200);
	endtask : tad_gap
	task automatic run_scan(input logic alt);
		logic [15:0] lo, hi, chb;
		logic onb;
		int idx, n, t;
		lo  = $random(seed);
		hi  = $random(seed) & 16'h0003;
		chb = $random(seed) & 16'h000f;
		wr_reg(4'h0, 16'h0000);
		wr_reg(4'h4, lo);
		wr_reg(4'h5, hi);
		wr_reg(4'h3, chb << 8);
		wr_reg(4'h2, 16'h000e);
		wr_reg(4'h1, 16'h0400 | {15'h0000, alt});
		smp <= 4'h3;
		wr_reg(4'h0, 16'h8000);
		idx = next_ch({hi[1:0], lo}, -1);
		n = 0;
		onb = 1'b0;
		wait_cyc(2);
		check("first scan channel", active_channel, idx);
		repeat (6) begin
			convert(t);
			n++;
			if (!alt || !onb) idx = next_ch({hi[1:0], lo}, idx);
			onb = alt && !onb;
			if (n == 3) begin
				n = 0;
				idx = next_ch({hi[1:0], lo}, -1);
				onb = 1'b0;
			end
			wait_cyc(4);
			check("scan channel", active_channel, onb ? chb : idx);
			check("mux b in use", mux_b_active, onb);
		end
		$display("test scan alt=%0d done", alt);
	endtask : run_scan
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_count++;
		$display("CHECK FAILED watchdog expected finish seen hang");
		tally_and_finish();
	end
	initial begin
		logic [15:0] v, d;
		int t;
		seed = 82;
		{srst, wr, rd, conv_start} = 4'h8;
		{addr, wdata, smp, rc_period} = 30'h0;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			rd_reg(i[3:0], v);
			check("reset value", v, 16'h0000);
		end
		for (int i = 1; i < 10; i++) begin
			if (i == 6) continue;
			d = $random(seed);
			if (i == 1 || i == 2) d = d & 16'h7fff;
			wr_reg(i[3:0], d);
			rd_reg(i[3:0], v);
			check("readback", v, d & impl_mask(i[3:0]));
		end
		$display("test registers done");
		wr_reg(4'h3, 16'h0001);
		for (int r = 0; r < 8; r++) begin
			wr_reg(4'h1, {r[2:0], 13'h0000});
			wait_cyc(2);
			check("upper ref", upper_ref_ext, r[2] ? 1'b0 : r[0]);
			check("lower ref", lower_ref_ext, r[2] ? 1'b0 : r[1]);
			check("shared pin channel", active_channel, 5'h01);
		end
		$display("test references done");
		for (int j = 0; j < 3; j++) begin
			d = (j == 0) ? 16'h000e : (j == 1) ? 16'h000f : 16'h003f;
			wr_reg(4'h0, 16'h0000);
			wr_reg(4'h2, d);
			wr_reg(4'h6, 16'h0003);
			wr_reg(4'h7, 16'h0001);
			wr_reg(4'h0, 16'h8000);
			tad_gap(t);
			check("tad period", t, d + 1);
			convert(t);
			check("tads per conversion", t, 12);
			check("busy after done", converting, 1'b0);
			wait_cyc(2);
			check("irq raised", irq, 1'b1);
			rd_reg(4'h6, v);
			check("done status", v[0], 1'b1);
			wr_reg(4'h6, 16'h0001);
			wait_cyc(2);
			check("irq cleared", irq, 1'b0);
		end
		$display("test divided clock done");
		wr_reg(4'h0, 16'h0000);
		// A start while the module is off must be ignored.
		@(posedge clk_sys);
		conv_start <= 1'b1;
		@(posedge clk_sys);
		conv_start <= 1'b0;
		wait_cyc(1);
		check("start refused while off", converting, 1'b0);
		wr_reg(4'h7, 16'h0000);
		wr_reg(4'h2, 16'h8000 | ($random(seed) & 16'h003f));
		rc_period <= 6'h11;
		wr_reg(4'h0, 16'h8000);
		tad_gap(t);
		check("rc tad period", t, 17);
		convert(t);
		check("rc tads per conversion", t, 12);
		wait_cyc(2);
		check("masked irq", irq, 1'b0);
		rc_period <= 6'h00;
		$display("test rc clock done");
		run_scan(1'b0);
		run_scan(1'b1);
		tally_and_finish();
	end
endmodule : tb_top
